// ### acs_pkg.sv
// package: register map, field layout and codes of the adc compare/status block
`default_nettype none
package acs_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [8:0] OFS_CMP0    = 9'h088;
	localparam logic [8:0] OFS_CMP1    = 9'h08C;
	localparam logic [8:0] OFS_STATUS  = 9'h090;
	localparam logic [8:0] OFS_VALID   = 9'h094;
	localparam logic [8:0] OFS_OVERRUN = 9'h098;
	localparam logic [8:0] OFS_TDELAY  = 9'h09C;
	localparam logic [8:0] OFS_DMAVAL  = 9'h100;

	// ----------------------------------------------------------------
	// compare register fields
	// ----------------------------------------------------------------
	localparam int CMP_EN_POS    = 0;
	localparam int CMP_IE_POS    = 1;
	localparam int CMP_COND_POS  = 2;
	localparam int CMP_CH_LSB    = 3;
	localparam int CMP_CNT_LSB   = 8;
	localparam int CMP_WEN_POS   = 15;
	localparam int CMP_THR_LSB   = 16;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int ST_END_POS    = 0;
	localparam int ST_COMPARE_FLAG_ZERO_POS  = 1;
	localparam int ST_COMPARE_FLAG_ONE_POS  = 2;
	localparam int ST_BUSY_POS   = 7;
	localparam int ST_VALID_POS  = 8;
	localparam int ST_OVR_POS    = 16;
	localparam int ST_CHAN_LSB   = 27;

	// ----------------------------------------------------------------
	// channel codes, modes, counts and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]  CH_LAST_EXT    = 5'h0B;
	localparam logic [4:0]  CH_BANDGAP     = 5'h1D;
	localparam logic [4:0]  CH_TEMP        = 5'h1E;
	localparam logic [31:0] CH_IMPL_MASK   = 32'h6000_0FFF;
	localparam logic [4:0]  BURST_END_LVL  = 5'h08;
	localparam int          DELAY_MULT_SH  = 2;
	localparam logic [31:0] RST_REG        = 32'h0000_0000;
	localparam logic [4:0]  CNT_ZERO       = 5'h00;
	localparam logic [9:0]  DLY_ZERO       = 10'h000;

	typedef enum logic [1:0] {
		ACS_MODE_SINGLE = 2'h0,
		ACS_MODE_BURST  = 2'h1,
		ACS_MODE_SCAN1  = 2'h2,
		ACS_MODE_SCANC  = 2'h3
	} acs_mode_t;

	// one comparator's settings
	typedef struct packed {
		logic [11:0] thr;
		logic        wen;
		logic [3:0]  lim;
		logic [4:0]  chan;
		logic        cond;
		logic        ie;
		logic        en;
	} acs_cmp_cfg_t;

	// a result as it is loaded into a result register
	typedef struct packed {
		logic        load;
		logic [4:0]  chan;
		logic [11:0] data;
	} acs_result_t;

endpackage
`default_nettype wire

// ### acs_monitor.sv
// module: adc result comparators, conversion status, trigger delay and dma monitor
`timescale 1ns/100ps
`default_nettype none

module acs_monitor (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// register port
	input  wire logic [8:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// converter core
	input  wire logic        i_result_load,
	input  wire logic [4:0]  i_result_chan,
	input  wire logic [11:0] i_result_data,
	input  wire logic [31:0] i_chan_valid,
	input  wire logic [31:0] i_chan_overrun,
	input  wire logic        i_conv_start,
	input  wire logic [1:0]  i_op_mode,
	input  wire logic [4:0]  i_cur_chan,
	input  wire logic [4:0]  i_next_chan,
	input  wire logic        i_single_done,
	input  wire logic        i_scan_done,
	input  wire logic [4:0]  i_fifo_level,
	input  wire logic        i_fifo_overrun,
	input  wire logic        i_burst_valid,
	input  wire logic        i_pwm_trig,
	input  wire logic        i_dma_xfer,
	input  wire logic [17:0] i_dma_data,
	// outputs
	output logic      [1:0]  o_cmp_irq,
	output logic             o_pwm_start,
	output logic             o_start_clear
);

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic wr_cmp0;
	logic wr_cmp1;
	logic wr_status;
	logic wr_tdelay;

	assign wr_cmp0   = i_wr && (i_addr == acs_pkg::OFS_CMP0);
	assign wr_cmp1   = i_wr && (i_addr == acs_pkg::OFS_CMP1);
	assign wr_status = i_wr && (i_addr == acs_pkg::OFS_STATUS);
	assign wr_tdelay = i_wr && (i_addr == acs_pkg::OFS_TDELAY);

	// ----------------------------------------------------------------
	// mode and result bundle
	// ----------------------------------------------------------------
	acs_pkg::acs_mode_t mode;
	acs_pkg::acs_result_t res;

	assign mode = acs_pkg::acs_mode_t'(i_op_mode);
	assign res  = '{load: i_result_load, chan: i_result_chan, data: i_result_data};

	// ----------------------------------------------------------------
	// compare registers
	// ----------------------------------------------------------------
	acs_pkg::acs_cmp_cfg_t cfg_q [2];
	logic [1:0]            wr_cmp;

	// reset pattern cut to the width of the settings struct
	localparam acs_pkg::acs_cmp_cfg_t CFG_RST = acs_pkg::acs_cmp_cfg_t'(acs_pkg::RST_REG[24:0]);

	assign wr_cmp = {wr_cmp1, wr_cmp0};

	function automatic acs_pkg::acs_cmp_cfg_t unpack_cfg(input logic [31:0] w, input logic has_wen);
		acs_pkg::acs_cmp_cfg_t c;
		c.thr  = w[acs_pkg::CMP_THR_LSB +: 12];
		c.wen  = has_wen & w[acs_pkg::CMP_WEN_POS];
		c.lim  = w[acs_pkg::CMP_CNT_LSB +: 4];
		c.chan = w[acs_pkg::CMP_CH_LSB +: 5];
		c.cond = w[acs_pkg::CMP_COND_POS];
		c.ie   = w[acs_pkg::CMP_IE_POS];
		c.en   = w[acs_pkg::CMP_EN_POS];
		return c;
	endfunction

	function automatic logic [31:0] pack_cfg(input acs_pkg::acs_cmp_cfg_t c);
		logic [31:0] w;
		w = acs_pkg::RST_REG;
		w[acs_pkg::CMP_THR_LSB +: 12] = c.thr;
		w[acs_pkg::CMP_WEN_POS]       = c.wen;
		w[acs_pkg::CMP_CNT_LSB +: 4]  = c.lim;
		w[acs_pkg::CMP_CH_LSB +: 5]   = c.chan;
		w[acs_pkg::CMP_COND_POS]      = c.cond;
		w[acs_pkg::CMP_IE_POS]        = c.ie;
		w[acs_pkg::CMP_EN_POS]        = c.en;
		return w;
	endfunction

	// a reserved select code never selects a result, even when the loaded channel is equal to it
	function automatic logic chan_ok(input logic [4:0] ch);
		return (ch <= acs_pkg::CH_LAST_EXT) || (ch == acs_pkg::CH_BANDGAP)
			|| (ch == acs_pkg::CH_TEMP);
	endfunction

	// ----------------------------------------------------------------
	// comparators
	// ----------------------------------------------------------------
	logic [1:0] cmp_hit;
	logic [4:0] match_cnt_q [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cmp
			logic        sel;
			logic        cond_met;
			logic [4:0]  cnt_inc;

			// window mode bit only exists in comparator 0
			// it is stored for software only; no window compare behaviour
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_b) begin
					cfg_q[g] <= CFG_RST;
				end else if (wr_cmp[g]) begin
					cfg_q[g] <= unpack_cfg(i_wdata, (g == 0));
				end
			end

			assign sel      = res.load && cfg_q[g].en && chan_ok(cfg_q[g].chan)
				&& (res.chan == cfg_q[g].chan);
			assign cond_met = cfg_q[g].cond ? (res.data >= cfg_q[g].thr)
				: (res.data < cfg_q[g].thr);
			assign cnt_inc  = match_cnt_q[g] + 5'h01;

			// counter saturates so a long run cannot wrap to a false hit
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_b) begin
					match_cnt_q[g] <= acs_pkg::CNT_ZERO;
				end else if (wr_cmp[g]) begin
					match_cnt_q[g] <= acs_pkg::CNT_ZERO;
				end else if (sel) begin
					if (!cond_met) begin
						match_cnt_q[g] <= acs_pkg::CNT_ZERO;
					end else if (match_cnt_q[g] != 5'h1F) begin
						match_cnt_q[g] <= cnt_inc;
					end
				end
			end

			assign cmp_hit[g] = sel && cond_met
				&& (cnt_inc == ({1'b0, cfg_q[g].lim} + 5'h01));
		end
	endgenerate

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	logic [1:0] cmp_flag_q;
	logic       end_flag_q;
	logic [1:0] clr_cmp;
	logic       clr_end;
	logic       end_set;

	assign clr_cmp = wr_status ? {i_wdata[acs_pkg::ST_COMPARE_FLAG_ONE_POS], i_wdata[acs_pkg::ST_COMPARE_FLAG_ZERO_POS]}
		: 2'h0;
	assign clr_end = wr_status && i_wdata[acs_pkg::ST_END_POS];

	// ----------------------------------------------------------------
	// end flag source per mode
	// ----------------------------------------------------------------
	always_comb begin
		case (mode)
			acs_pkg::ACS_MODE_SINGLE: end_set = i_single_done;
			acs_pkg::ACS_MODE_SCAN1,
			acs_pkg::ACS_MODE_SCANC:  end_set = i_scan_done;
			acs_pkg::ACS_MODE_BURST:  end_set = i_fifo_level > acs_pkg::BURST_END_LVL;
			default:                  end_set = 1'b0;
		endcase
	end

	// a set in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			cmp_flag_q <= 2'h0;
		end else begin
			cmp_flag_q <= (cmp_flag_q & ~clr_cmp) | cmp_hit;
		end
	end

	// in burst a fifo level above BURST_END_LVL keeps setting it, so a clear sticks only at or below that level
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			end_flag_q <= 1'b0;
		end else begin
			end_flag_q <= (end_flag_q & ~clr_end) | end_set;
		end
	end

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_cmp_irq <= 2'h0;
		end else begin
			o_cmp_irq <= cmp_flag_q & {cfg_q[1].ie, cfg_q[0].ie};
		end
	end

	// ----------------------------------------------------------------
	// start bit auto-clear
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_start_clear <= 1'b0;
		end else begin
			o_start_clear <= ((mode == acs_pkg::ACS_MODE_SINGLE) && i_single_done)
				|| ((mode == acs_pkg::ACS_MODE_SCAN1) && i_scan_done);
		end
	end

	// ----------------------------------------------------------------
	// pwm trigger delay
	// ----------------------------------------------------------------
	logic [7:0] dly_field_q;
	logic [9:0] dly_cnt_q;
	logic       dly_run_q;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			dly_field_q <= acs_pkg::RST_REG[7:0];
		end else if (wr_tdelay) begin
			dly_field_q <= i_wdata[7:0];
		end
	end

	// a trigger during a running delay restarts it
	// start comes four times the field plus two cycles after the trigger cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			dly_cnt_q   <= acs_pkg::DLY_ZERO;
			dly_run_q   <= 1'b0;
			o_pwm_start <= 1'b0;
		end else begin
			o_pwm_start <= 1'b0;
			if (i_pwm_trig) begin
				dly_cnt_q <= {dly_field_q, 2'b00};
				dly_run_q <= 1'b1;
			end else if (dly_run_q) begin
				if (dly_cnt_q == acs_pkg::DLY_ZERO) begin
					o_pwm_start <= 1'b1;
					dly_run_q   <= 1'b0;
				end else begin
					dly_cnt_q <= dly_cnt_q - 10'h001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// dma monitor
	// ----------------------------------------------------------------
	// last moved word stays readable until the next transfer
	logic [17:0] dma_val_q;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			dma_val_q <= acs_pkg::RST_REG[17:0];
		end else if (i_dma_xfer) begin
			dma_val_q <= i_dma_data;
		end
	end

	// ----------------------------------------------------------------
	// status views
	// ----------------------------------------------------------------
	logic        burst;
	logic [31:0] valid_view;
	logic [31:0] ovr_view;
	logic [31:0] status_view;

	assign burst      = (mode == acs_pkg::ACS_MODE_BURST);
	assign valid_view = acs_pkg::CH_IMPL_MASK
		& (i_chan_valid | {32{burst & i_burst_valid}});
	assign ovr_view   = acs_pkg::CH_IMPL_MASK
		& (i_chan_overrun | {32{burst & i_fifo_overrun}});

	always_comb begin
		status_view = acs_pkg::RST_REG;
		status_view[acs_pkg::ST_CHAN_LSB +: 5] = i_conv_start ? i_cur_chan : i_next_chan;
		status_view[acs_pkg::ST_OVR_POS]   = |ovr_view;
		status_view[acs_pkg::ST_VALID_POS] = |valid_view;
		status_view[acs_pkg::ST_BUSY_POS]  = i_conv_start;
		status_view[acs_pkg::ST_COMPARE_FLAG_ONE_POS] = cmp_flag_q[1];
		status_view[acs_pkg::ST_COMPARE_FLAG_ZERO_POS] = cmp_flag_q[0];
		status_view[acs_pkg::ST_END_POS]   = end_flag_q;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_rdata <= acs_pkg::RST_REG;
		end else if (i_rd) begin
			case (i_addr)
				acs_pkg::OFS_CMP0:    o_rdata <= pack_cfg(cfg_q[0]);
				acs_pkg::OFS_CMP1:    o_rdata <= pack_cfg(cfg_q[1]);
				acs_pkg::OFS_STATUS:  o_rdata <= status_view;
				acs_pkg::OFS_VALID:   o_rdata <= valid_view;
				acs_pkg::OFS_OVERRUN: o_rdata <= ovr_view;
				acs_pkg::OFS_TDELAY:  o_rdata <= {24'h000000, dly_field_q};
				acs_pkg::OFS_DMAVAL:  o_rdata <= {14'h0000, dma_val_q};
				default:              o_rdata <= acs_pkg::RST_REG;
			endcase
		end else begin
			o_rdata <= acs_pkg::RST_REG;
		end
	end

endmodule // acs_monitor
`default_nettype wire

// ### acs_monitor_checker.sv
// checker: port-level assertions for the adc compare/status block
`timescale 1ns/100ps
`default_nettype none
module acs_monitor_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_b,
	input wire logic [8:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [31:0] i_chan_valid,
	input wire logic [31:0] i_chan_overrun,
	input wire logic        i_conv_start,
	input wire logic [1:0]  i_op_mode,
	input wire logic [4:0]  i_cur_chan,
	input wire logic [4:0]  i_next_chan,
	input wire logic        i_fifo_overrun,
	input wire logic        i_burst_valid,
	input wire logic        i_single_done,
	input wire logic        i_scan_done,
	input wire logic        i_pwm_trig,
	input wire logic [1:0]  o_cmp_irq,
	input wire logic        o_pwm_start,
	input wire logic        o_start_clear
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	localparam logic [31:0] M = acs_pkg::CH_IMPL_MASK;
	logic        brst;
	logic [7:0]  dly_q;
	logic [10:0] cnt_q;
	assign brst = i_op_mode == 2'h1;
	// ----------------------------------------------------------------
	// reference count of the trigger delay
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b)
			dly_q <= 8'h00;
		else if (i_wr && i_addr == acs_pkg::OFS_TDELAY)
			dly_q <= i_wdata[7:0];
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b)
			cnt_q <= 11'h000;
		else if (i_pwm_trig)
			cnt_q <= {1'b0, dly_q, 2'b00} + 11'h002;
		else if (cnt_q != 11'h000)
			cnt_q <= cnt_q - 11'h001;
	end
	sequence s_rd(logic [8:0] a);
		i_rd && i_addr == a;
	endsequence
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	chk_busy_mirror: assert property (s_rd(acs_pkg::OFS_STATUS) |=> o_rdata[7] == $past(i_conv_start))
		else $error("busy bit differs from start bit");
	chk_status_chan: assert property (s_rd(acs_pkg::OFS_STATUS) |=>
		o_rdata[31:27] == ($past(i_conv_start) ? $past(i_cur_chan) : $past(i_next_chan)))
		else $error("status channel wrong");
	chk_any_overrun: assert property (s_rd(acs_pkg::OFS_STATUS) |=>
		o_rdata[16] == $past(|(i_chan_overrun & M) || (brst && i_fifo_overrun)))
		else $error("any overrun flag wrong");
	chk_any_valid: assert property (s_rd(acs_pkg::OFS_STATUS) |=>
		o_rdata[8] == $past(|(i_chan_valid & M) || (brst && i_burst_valid)))
		else $error("any valid flag wrong");
	chk_valid_mirror: assert property (s_rd(acs_pkg::OFS_VALID) |=>
		o_rdata == ($past(i_chan_valid | {32{brst && i_burst_valid}}) & M))
		else $error("valid mirror wrong");
	chk_ovr_mirror: assert property (s_rd(acs_pkg::OFS_OVERRUN) |=>
		o_rdata == ($past(i_chan_overrun | {32{brst && i_fifo_overrun}}) & M))
		else $error("overrun mirror wrong");
	chk_irq_drop: assert property ($fell(o_cmp_irq[0]) || $fell(o_cmp_irq[1]) |-> $past(i_wr, 2))
		else $error("interrupt dropped without a write");
	chk_pwm_delay: assert property (o_pwm_start == (cnt_q == 11'h001))
		else $error("delayed start at wrong cycle");
	chk_start_clear: assert property (o_start_clear |->
		$past((i_single_done && i_op_mode == 2'h0) || (i_scan_done && i_op_mode == 2'h2)))
		else $error("start clear without single end");
endmodule // acs_monitor_checker
`default_nettype wire

// ### acs_core_model.sv
// partner: behavioural converter core and dma feeding the monitor
`timescale 1ns/100ps
`default_nettype none
module acs_core_model (
	input  wire logic   i_clk_sys,
	output logic        o_load,
	output logic [4:0]  o_chan,
	output logic [11:0] o_data,
	output logic [31:0] o_valid,
	output logic [31:0] o_ovr,
	output logic        o_start,
	output logic [1:0]  o_mode,
	output logic [4:0]  o_cur,
	output logic [4:0]  o_next,
	output logic        o_sdone,
	output logic        o_scdone,
	output logic [4:0]  o_fifo,
	output logic        o_fovr,
	output logic        o_bval,
	output logic        o_trig,
	output logic        o_xfer,
	output logic [17:0] o_dma
);
	initial begin
		{o_load, o_chan, o_data, o_valid, o_ovr, o_start, o_mode, o_cur, o_next} = '0;
		{o_sdone, o_scdone, o_fifo, o_fovr, o_bval, o_trig, o_xfer, o_dma} = '0;
	end
	// ----------------------------------------------------------------
	// levels held between events, and one-cycle events
	// ----------------------------------------------------------------
	task automatic set(input logic s, input logic [1:0] m, input logic [4:0] c, n, f,
		input logic [31:0] v, o, input logic fo, bv);
		@(posedge i_clk_sys);
		{o_start, o_mode, o_cur, o_next, o_fifo, o_valid, o_ovr, o_fovr, o_bval} <=
			{s, m, c, n, f, v, o, fo, bv};
	endtask
	// kind: 0 result load, 1 single end, 2 scan end, 3 trigger, 4 dma word
	task automatic pulse(input int k, input logic [4:0] c, input logic [17:0] d);
		@(posedge i_clk_sys);
		o_chan <= c;
		o_data <= d[11:0];
		o_dma <= d;
		{o_load, o_sdone, o_scdone, o_trig, o_xfer} <= 5'(5'h10 >> k);
		@(posedge i_clk_sys);
		{o_load, o_sdone, o_scdone, o_trig, o_xfer} <= 5'h00;
		// stale data must not look valid once the event is gone
		o_data <= ~d[11:0];
		o_dma <= ~d;
	endtask
endmodule // acs_core_model
`default_nettype wire

// ### tb_adc_compare_status_logic.sv
// testbench: register-level tests of the adc compare/status block
`timescale 1ns/100ps
`default_nettype none
module tb_adc_compare_status_logic;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [8:0]  i_addr = 9'h000;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [31:0] o_rdata, i_chan_valid, i_chan_overrun;
	logic [1:0]  o_cmp_irq, i_op_mode;
	logic [4:0]  i_result_chan, i_cur_chan, i_next_chan, i_fifo_level;
	logic [11:0] i_result_data;
	logic [17:0] i_dma_data;
	logic        i_result_load, i_conv_start, i_single_done, i_scan_done, i_fifo_overrun;
	logic        i_burst_valid, i_pwm_trig, i_dma_xfer, o_pwm_start, o_start_clear;
	int          num_errors = 0;
	int          n_compared = 0;
	int          k;
	logic [8:0]  regs [8] = '{9'h088, 9'h08C, 9'h090, 9'h094, 9'h098, 9'h09C, 9'h100, 9'h0A0};
	logic [1:0]  md [3] = '{2'h0, 2'h2, 2'h3};
	logic        sc [3] = '{1'b1, 1'b1, 1'b0};
	acs_monitor i_dut (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_result_load, .i_result_chan, .i_result_data, .i_chan_valid, .i_chan_overrun,
		.i_conv_start, .i_op_mode, .i_cur_chan, .i_next_chan, .i_single_done, .i_scan_done,
		.i_fifo_level, .i_fifo_overrun, .i_burst_valid, .i_pwm_trig, .i_dma_xfer, .i_dma_data,
		.o_cmp_irq, .o_pwm_start, .o_start_clear);
	acs_core_model i_core (.i_clk_sys, .o_load(i_result_load), .o_chan(i_result_chan),
		.o_data(i_result_data), .o_valid(i_chan_valid), .o_ovr(i_chan_overrun),
		.o_start(i_conv_start), .o_mode(i_op_mode), .o_cur(i_cur_chan), .o_next(i_next_chan),
		.o_sdone(i_single_done), .o_scdone(i_scan_done), .o_fifo(i_fifo_level),
		.o_fovr(i_fifo_overrun), .o_bval(i_burst_valid), .o_trig(i_pwm_trig),
		.o_xfer(i_dma_xfer), .o_dma(i_dma_data));
	initial forever #5 i_clk_sys = ~i_clk_sys;
	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			num_errors++;
		end
	endtask
	task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [8:0] a, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 chk("rdata", o_rdata, e);
	endtask
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		foreach (regs[i]) rd_reg(regs[i], 32'h0000_0000);
		wr_reg(acs_pkg::OFS_TDELAY, 32'hFFFF_FFFF);
		rd_reg(acs_pkg::OFS_TDELAY, 32'h0000_00FF);
		wr_reg(acs_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0000);
		wr_reg(acs_pkg::OFS_CMP0, 32'hFFFF_FFFF);
		rd_reg(acs_pkg::OFS_CMP0, 32'h0FFF_8FFF);
		// threshold 0x100, limit 1, channel 5, below, irq on
		wr_reg(acs_pkg::OFS_CMP0, 32'h0100_012B);
		i_core.pulse(0, 5'h05, 18'h000FF);
		i_core.pulse(0, 5'h05, 18'h00100);
		i_core.pulse(0, 5'h05, 18'h00050);
		i_core.pulse(0, 5'h03, 18'h00000);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0000);
		i_core.pulse(0, 5'h05, 18'h00000);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0002);
		chk("irq", {30'h0, o_cmp_irq}, 32'h0000_0001);
		wr_reg(acs_pkg::OFS_STATUS, 32'h0000_0002);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0000);
		chk("irq", {30'h0, o_cmp_irq}, 32'h0000_0000);
		// comparator 1: at or above 0xFFF, limit 0, irq off
		wr_reg(acs_pkg::OFS_CMP1, 32'h0FFF_00FD);
		i_core.pulse(0, 5'h1F, 18'h00FFF);
		wr_reg(acs_pkg::OFS_CMP0, 32'h0100_002A);
		i_core.pulse(0, 5'h05, 18'h00000);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0000);
		wr_reg(acs_pkg::OFS_CMP1, 32'h0FFF_00F5);
		i_core.pulse(0, 5'h1E, 18'h00FFE);
		i_core.pulse(0, 5'h1E, 18'h00FFF);
		rd_reg(acs_pkg::OFS_STATUS, 32'h0000_0004);
		chk("irq", {30'h0, o_cmp_irq}, 32'h0000_0000);
		wr_reg(acs_pkg::OFS_STATUS, 32'h0000_0004);
		i_core.set(1'b1, 2'h1, 5'h1E, 5'h03, 5'h08, 32'h0, 32'h0, 1'b1, 1'b1);
		rd_reg(acs_pkg::OFS_STATUS, 32'hF001_0180);
		rd_reg(acs_pkg::OFS_VALID, 32'h6000_0FFF);
		rd_reg(acs_pkg::OFS_OVERRUN, 32'h6000_0FFF);
		i_core.set(1'b1, 2'h1, 5'h1E, 5'h03, 5'h09, 32'h0, 32'h0, 1'b1, 1'b1);
		rd_reg(acs_pkg::OFS_STATUS, 32'hF001_0181);
		for (k = 0; k < 3; k++) begin
			i_core.set(1'b0, md[k], 5'h1E, 5'h03, 5'h00, 32'h2000_1001, 32'h4000_0000, 1'b1, 1'b1);
			wr_reg(acs_pkg::OFS_STATUS, 32'h0000_0001);
			rd_reg(acs_pkg::OFS_VALID, 32'h2000_0001);
			rd_reg(acs_pkg::OFS_OVERRUN, 32'h4000_0000);
			i_core.pulse(k == 0 ? 1 : 2, 5'h00, 18'h00000);
			#1 chk("start_clear", {31'h0, o_start_clear}, {31'h0, sc[k]});
			rd_reg(acs_pkg::OFS_STATUS, 32'h1801_0101);
		end
		wr_reg(acs_pkg::OFS_TDELAY, 32'h0000_0002);
		i_core.pulse(3, 5'h00, 18'h00000);
		for (k = 1; k < 60; k++) begin
			#1;
			if (o_pwm_start === 1'b1)
				break;
			@(posedge i_clk_sys);
		end
		chk("pwm_delay", k, 32'd10);
		if (k == 60)
			finish_test();
		i_core.pulse(4, 5'h00, 18'h2ABCD);
		rd_reg(acs_pkg::OFS_DMAVAL, 32'h0002_ABCD);
		finish_test();
	end
endmodule // tb_adc_compare_status_logic
bind acs_monitor acs_monitor_checker i_chk (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_chan_valid, .i_chan_overrun, .i_conv_start, .i_op_mode, .i_cur_chan,
	.i_next_chan, .i_fifo_overrun, .i_burst_valid, .i_single_done, .i_scan_done, .i_pwm_trig,
	.o_cmp_irq, .o_pwm_start, .o_start_clear);
`default_nettype wire
